// ---- fspp_pkg.sv ----
// Purpose: Shared constants for the fault-share pin propagation block
// Assumes: 100 MHz system clock
// Notes:   Bit positions index the propagation mask word
package fspp_pkg;

  localparam logic [7:0]  CMD_PROPAGATE_MASK = 8'hd2;
  localparam logic [15:0] MASK_RESET         = 16'h2993;
  localparam logic [15:0] MASK_RESERVED      = 16'h0668;

  localparam int BIT_DECAY_HOLD  = 15;
  localparam int BIT_SHORT_CYCLE = 14;
  localparam int BIT_TON_MAX     = 13;
  localparam int BIT_PG_CMP      = 12;
  localparam int BIT_INT_OT      = 11;
  localparam int BIT_EXT_UT      = 8;
  localparam int BIT_EXT_OT      = 7;
  localparam int BIT_VIN_OV      = 4;
  localparam int BIT_IOUT_OC     = 2;
  localparam int BIT_VOUT_UV     = 1;
  localparam int BIT_VOUT_OV     = 0;

  localparam logic [1:0] RESP_IGNORE   = 2'h0;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h2;

  localparam logic [7:0] PIN_RESP_INHIBIT = 8'hc0;
  localparam logic [7:0] PIN_RESP_IGNORE  = 8'h00;

  localparam int CLK_PERIOD_NS      = 10;
  localparam int SHORT_HOLD_MS      = 120;
  localparam int SHORT_HOLD_CYCLES  =
    SHORT_HOLD_MS * (1000000 / CLK_PERIOD_NS);
  localparam int HOLD_CNT_W         = 24;

  typedef enum logic [1:0] {
    FSPP_RUNNING  = 2'b00,
    FSPP_OFF_SEQ  = 2'b01,
    FSPP_SHORT_ON = 2'b10,
    FSPP_RELEASE  = 2'b11
  } fspp_cycle_e;

  function automatic logic fspp_acts(input logic [1:0] resp);
    return resp != RESP_IGNORE; // R2
  endfunction : fspp_acts

endpackage : fspp_pkg

// ---- fspp_mask_reg.sv ----
// Purpose: One page of the fault propagation mask word
// Assumes: Write and restore strobes are one-cycle pulses
// Notes:   Restore from nonvolatile store wins over a bus write
`timescale 1ns/1ps
`default_nettype none
module fspp_mask_reg (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        wr_en_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        restore_en_in,
  input  wire logic [15:0] restore_data_in,
  output logic      [15:0] mask_out
);
  import fspp_pkg::*;

  logic [15:0] mask_r;
  logic [15:0] mask_nxt;

  assign mask_nxt = restore_en_in ? restore_data_in :
                    wr_en_in      ? wr_data_in      : mask_r;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) mask_r <= MASK_RESET;
    else             mask_r <= mask_nxt;
  end

  assign mask_out = mask_r;
endmodule : fspp_mask_reg
`default_nettype wire

// ---- fspp_cycle_track.sv ----
// Purpose: Tracks off/on cycling of one channel for the pin holds
// Assumes: run_cmd_in is the combined commanded-on level
// Notes:   Hold length is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
module fspp_cycle_track #(
  parameter int HOLD_CYCLES = fspp_pkg::SHORT_HOLD_CYCLES
) (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic run_cmd_in,
  input  wire logic off_seq_done_in,
  input  wire logic decayed_in,
  input  wire logic multiphase_in,
  output logic      short_hold_out,
  output logic      decay_hold_out
);
  import fspp_pkg::*;

  localparam logic [HOLD_CNT_W-1:0] HOLD_LAST =
    HOLD_CNT_W'(HOLD_CYCLES - 1);

  fspp_cycle_e              state_r;
  fspp_cycle_e              state_nxt;
  logic [HOLD_CNT_W-1:0]    cnt_r;
  logic                     run_d_r;
  logic                     decay_r;
  wire                      run_rise = run_cmd_in & ~run_d_r;
  wire                      run_fall = ~run_cmd_in & run_d_r;
  wire                      cnt_done = (cnt_r == HOLD_LAST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FSPP_RUNNING:  if (run_fall) state_nxt = FSPP_OFF_SEQ;
      FSPP_OFF_SEQ: begin
        if (off_seq_done_in)  state_nxt = FSPP_RUNNING;
        else if (run_rise)    state_nxt = FSPP_SHORT_ON; // R5
      end
      FSPP_SHORT_ON: if (off_seq_done_in) state_nxt = FSPP_RELEASE; // R5
      FSPP_RELEASE:  if (cnt_done) state_nxt = FSPP_RUNNING; // R5
      default:       state_nxt = FSPP_RUNNING;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= FSPP_RUNNING;
      cnt_r   <= '0;
      // Matches the running state, so no false restart edge after reset
      run_d_r <= 1'b1;
      decay_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      run_d_r <= run_cmd_in;
      cnt_r   <= (state_r == FSPP_RELEASE) ? cnt_r + 1'b1 : '0;
      // Restart before decay is held off until the output falls
      if (decayed_in || !run_cmd_in) decay_r <= 1'b0; // R4
      else if (run_rise && multiphase_in) decay_r <= 1'b1; // R4
    end
  end

  assign short_hold_out = (state_r == FSPP_SHORT_ON) ||
                          (state_r == FSPP_RELEASE);
  assign decay_hold_out = decay_r;

  property p_short_release;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (state_r == FSPP_RELEASE && cnt_done) |=> !short_hold_out;
  endproperty
  a_short_release: assert property (p_short_release) // R5
    else $error("short-cycle hold not released after count");

  property p_decay_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (run_rise && multiphase_in && !decayed_in) |=> decay_hold_out;
  endproperty
  a_decay_hold: assert property (p_decay_hold) // R4
    else $error("decay hold not raised on early restart");
endmodule : fspp_cycle_track
`default_nettype wire

// ---- fspp_top.sv ----
// Purpose: Drives two open-drain fault-share pins from enabled faults
// Assumes: Fault inputs are synchronous levels, high when asserted
// Notes:   Notes on behaviour listed below
//
// Notes on behaviour
// [R1] Paged 16-bit mask at 0xd2, default 0x2993
// [R2] Ignored-response faults never reach the pin
// [R3] Pin 0 serves page 0, pin 1 page 1
// [R4] Early multiphase restart holds pin until decayed
// [R5] Short off/on cycle pulls pin, 120ms release
// [R6] Bit 13 maps turn-on timeout fault
// [R7] Bit 12 follows raw power-good comparator
// [R8] Bit 11 maps internal overtemperature
// [R9] Bit 8 maps external undertemperature
// [R10] Bit 7 maps external overtemperature
// [R11] Bit 4 maps input overvoltage
// [R12] Bit 2 maps output overcurrent
// [R13] Bit 1 maps output undervoltage
// [R14] Bit 0 maps output overvoltage
// [R15] Response 10 shuts down, 00 runs on
// [R16] Pin response 0xc0 three-states on external low
// [R17] Reserved mask bits written zero, ignored
// [R18] Pin pull is OR of enabled conditions
`timescale 1ns/1ps
`default_nettype none
module fspp_top #(
  parameter int SHORT_HOLD_CYC = fspp_pkg::SHORT_HOLD_CYCLES
) (
  input  wire logic            sys_clk_in,
  input  wire logic            reset_n_in,
  input  wire logic            cmd_valid_in,
  input  wire logic            cmd_write_in,
  input  wire logic [7:0]      cmd_code_in,
  input  wire logic            cmd_page_in,
  input  wire logic [15:0]     cmd_wdata_in,
  output logic      [15:0]     cmd_rdata_out,
  output logic                 cmd_hit_out,
  input  wire logic            nvm_restore_in,
  input  wire logic [15:0]     nvm_mask0_in,
  input  wire logic [15:0]     nvm_mask1_in,
  output logic      [15:0]     nvm_mask0_out,
  output logic      [15:0]     nvm_mask1_out,
  input  wire logic [1:0]      run_cmd_in,
  input  wire logic [1:0]      off_seq_done_in,
  input  wire logic [1:0]      decayed_in,
  input  wire logic [1:0]      chan_cfg_bit0_in,
  input  wire logic [1:0]      ton_max_fault_in,
  input  wire logic [1:0]      power_good_cmp_uv_in,
  input  wire logic            internal_overtemperature_fault_in,
  input  wire logic [1:0]      external_undertemperature_fault_in,
  input  wire logic [1:0]      external_overtemperature_fault_in,
  input  wire logic            input_overvoltage_fault_in,
  input  wire logic [1:0]      output_overcurrent_fault_in,
  input  wire logic [1:0]      output_undervoltage_fault_in,
  input  wire logic [1:0]      output_overvoltage_fault_in,
  input  wire logic [1:0][1:0] resp_ton_max_in,
  input  wire logic [1:0][1:0] resp_int_ot_in,
  input  wire logic [1:0][1:0] resp_ext_ut_in,
  input  wire logic [1:0][1:0] resp_ext_ot_in,
  input  wire logic [1:0][1:0] resp_vin_ov_in,
  input  wire logic [1:0][1:0] resp_iout_oc_in,
  input  wire logic [1:0][1:0] resp_vout_uv_in,
  input  wire logic [1:0][1:0] resp_vout_ov_in,
  input  wire logic [1:0][7:0] pin_resp_in,
  input  wire logic [1:0]      fault_share_pin_in,
  output logic      [1:0]      fault_share_pin_out,
  output logic      [1:0]      fault_share_pin_oe_n_out,
  output logic      [1:0]      shutdown_req_out,
  output logic      [1:0]      tristate_req_out
);
  import fspp_pkg::*;

  // Command decode
  wire        cmd_hit  = cmd_valid_in && (cmd_code_in == CMD_PROPAGATE_MASK);
  wire        wr_hit   = cmd_hit && cmd_write_in;
  wire        wr_page0 = wr_hit && !cmd_page_in; // R1
  wire        wr_page1 = wr_hit &&  cmd_page_in; // R1
  wire [15:0] mask0;
  wire [15:0] mask1;
  wire [15:0] rd_sel   = cmd_page_in ? mask1 : mask0;

  logic [15:0] rdata_r;
  logic        hit_r;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= '0;
      hit_r   <= 1'b0;
    end else begin
      hit_r   <= cmd_hit;
      rdata_r <= (cmd_hit && !cmd_write_in) ? rd_sel : rdata_r; // R1
    end
  end

  assign cmd_rdata_out = rdata_r;
  assign cmd_hit_out   = hit_r;
  assign nvm_mask0_out = mask0;
  assign nvm_mask1_out = mask1;

  fspp_mask_reg u_mask0 (
    .sys_clk_in      (sys_clk_in),
    .reset_n_in      (reset_n_in),
    .wr_en_in        (wr_page0),
    .wr_data_in      (cmd_wdata_in),
    .restore_en_in   (nvm_restore_in),
    .restore_data_in (nvm_mask0_in),
    .mask_out        (mask0)
  );

  fspp_mask_reg u_mask1 (
    .sys_clk_in      (sys_clk_in),
    .reset_n_in      (reset_n_in),
    .wr_en_in        (wr_page1),
    .wr_data_in      (cmd_wdata_in),
    .restore_en_in   (nvm_restore_in),
    .restore_data_in (nvm_mask1_in),
    .mask_out        (mask1)
  );

  // Per-page condition vectors, laid out like the mask word
  logic [15:0]      cond [2];
  logic [1:0][15:0] live;
  logic [1:0]       short_hold;
  logic [1:0]       decay_hold;
  logic [1:0]       pull_r;
  logic [1:0]       shut_r;
  logic [1:0]       tri_r;
  logic [1:0]       pull_nxt;
  logic [1:0]       shut_nxt;
  logic [1:0]       tri_nxt;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      fspp_cycle_track #(
        .HOLD_CYCLES (SHORT_HOLD_CYC)
      ) u_track (
        .sys_clk_in      (sys_clk_in),
        .reset_n_in      (reset_n_in),
        .run_cmd_in      (run_cmd_in[ch]),
        .off_seq_done_in (off_seq_done_in[ch]),
        .decayed_in      (decayed_in[ch]),
        .multiphase_in   (!chan_cfg_bit0_in[ch]), // R4
        .short_hold_out  (short_hold[ch]),
        .decay_hold_out  (decay_hold[ch])
      );

      // Faults only count when their response acts on them
      always_comb begin
        cond[ch] = '0;
        cond[ch][BIT_DECAY_HOLD]  = decay_hold[ch]; // R4
        cond[ch][BIT_SHORT_CYCLE] = short_hold[ch]; // R5
        cond[ch][BIT_TON_MAX]     = ton_max_fault_in[ch] &&
                                    fspp_acts(resp_ton_max_in[ch]); // R6
        cond[ch][BIT_PG_CMP]      = power_good_cmp_uv_in[ch]; // R7
        cond[ch][BIT_INT_OT]      = internal_overtemperature_fault_in &&
                                    fspp_acts(resp_int_ot_in[ch]); // R8
        cond[ch][BIT_EXT_UT]      = external_undertemperature_fault_in[ch] &&
                                    fspp_acts(resp_ext_ut_in[ch]); // R9
        cond[ch][BIT_EXT_OT]      = external_overtemperature_fault_in[ch] &&
                                    fspp_acts(resp_ext_ot_in[ch]); // R10
        cond[ch][BIT_VIN_OV]      = input_overvoltage_fault_in &&
                                    fspp_acts(resp_vin_ov_in[ch]); // R11
        cond[ch][BIT_IOUT_OC]     = output_overcurrent_fault_in[ch] &&
                                    fspp_acts(resp_iout_oc_in[ch]); // R12
        cond[ch][BIT_VOUT_UV]     = output_undervoltage_fault_in[ch] &&
                                    fspp_acts(resp_vout_uv_in[ch]); // R13
        cond[ch][BIT_VOUT_OV]     = output_overvoltage_fault_in[ch] &&
                                    fspp_acts(resp_vout_ov_in[ch]); // R14
      end

      // Reserved bits masked off so stray writes cannot pull the pin
      assign live[ch] = cond[ch] & (ch == 0 ? mask0 : mask1) &
                        ~MASK_RESERVED; // R3 R17
      assign pull_nxt[ch] = |live[ch]; // R18

      assign shut_nxt[ch] =
        (ton_max_fault_in[ch] && resp_ton_max_in[ch] == RESP_SHUTDOWN) ||
        (internal_overtemperature_fault_in &&
         resp_int_ot_in[ch] == RESP_SHUTDOWN) ||
        (external_undertemperature_fault_in[ch] &&
         resp_ext_ut_in[ch] == RESP_SHUTDOWN) ||
        (external_overtemperature_fault_in[ch] &&
         resp_ext_ot_in[ch] == RESP_SHUTDOWN) ||
        (input_overvoltage_fault_in &&
         resp_vin_ov_in[ch] == RESP_SHUTDOWN) ||
        (output_overcurrent_fault_in[ch] &&
         resp_iout_oc_in[ch] == RESP_SHUTDOWN) ||
        (output_undervoltage_fault_in[ch] &&
         resp_vout_uv_in[ch] == RESP_SHUTDOWN) ||
        (output_overvoltage_fault_in[ch] &&
         resp_vout_ov_in[ch] == RESP_SHUTDOWN); // R15

      // Own pull-down would look like an external one, so exclude it
      assign tri_nxt[ch] = !fault_share_pin_in[ch] && !pull_r[ch] &&
                           (pin_resp_in[ch] == PIN_RESP_INHIBIT); // R16
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pull_r <= '0;
      shut_r <= '0;
      tri_r  <= '0;
    end else begin
      pull_r <= pull_nxt; // R18
      shut_r <= shut_nxt; // R15
      tri_r  <= tri_nxt;  // R16
    end
  end

  assign fault_share_pin_out      = '0;
  assign fault_share_pin_oe_n_out = ~pull_r; // R18
  assign shutdown_req_out         = shut_r;
  assign tristate_req_out         = tri_r;

  property p_mask_write;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (wr_page0 && !nvm_restore_in) |=> mask0 == $past(cmd_wdata_in);
  endproperty
  a_mask_write: assert property (p_mask_write) // R1
    else $error("page 0 mask write not stored");

  property p_mask_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (cmd_hit && !cmd_write_in && cmd_page_in) |=>
        cmd_hit_out && cmd_rdata_out == $past(mask1);
  endproperty
  a_mask_read: assert property (p_mask_read) // R1
    else $error("page 1 mask read returned wrong word");

  property p_ignored_fault;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (resp_ton_max_in[0] == RESP_IGNORE) |-> !cond[0][BIT_TON_MAX];
  endproperty
  a_ignored_fault: assert property (p_ignored_fault) // R2
    else $error("ignored fault reached pin condition");

  property p_page_isolation;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (live[1] == '0) |=> fault_share_pin_oe_n_out[1];
  endproperty
  a_page_isolation: assert property (p_page_isolation) // R3
    else $error("pin 1 pulled with no page 1 condition");

  property p_ton_max;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (mask0[BIT_TON_MAX] && ton_max_fault_in[0] &&
       resp_ton_max_in[0] != RESP_IGNORE) |=>
        !fault_share_pin_oe_n_out[0];
  endproperty
  a_ton_max: assert property (p_ton_max) // R6
    else $error("turn-on timeout did not pull pin 0");

  property p_pg_follow;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (mask1[BIT_PG_CMP] && power_good_cmp_uv_in[1]) |=>
        !fault_share_pin_oe_n_out[1];
  endproperty
  a_pg_follow: assert property (p_pg_follow) // R7
    else $error("pin 1 did not follow comparator");

  property p_int_ot;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (mask0[BIT_INT_OT] && internal_overtemperature_fault_in &&
       resp_int_ot_in[0] != RESP_IGNORE) |=> !fault_share_pin_oe_n_out[0];
  endproperty
  a_int_ot: assert property (p_int_ot) // R8
    else $error("internal overtemperature did not pull pin 0");

  property p_vin_ov;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (mask1[BIT_VIN_OV] && input_overvoltage_fault_in &&
       resp_vin_ov_in[1] != RESP_IGNORE) |=> !fault_share_pin_oe_n_out[1];
  endproperty
  a_vin_ov: assert property (p_vin_ov) // R11
    else $error("input overvoltage did not pull pin 1");

  property p_reserved;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      ((live[0] | live[1]) & MASK_RESERVED) == '0;
  endproperty
  a_reserved: assert property (p_reserved) // R17
    else $error("reserved mask bit reached a pin");

  property p_shutdown;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (output_overvoltage_fault_in[0] &&
       resp_vout_ov_in[0] == RESP_SHUTDOWN) |=> shutdown_req_out[0];
  endproperty
  a_shutdown: assert property (p_shutdown) // R15
    else $error("shutdown response not requested");

  property p_inhibit;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (!fault_share_pin_in[1] && !pull_r[1] &&
       pin_resp_in[1] == PIN_RESP_INHIBIT) |=> tristate_req_out[1] ##1
      (tristate_req_out[1] || fault_share_pin_in[1] || pull_r[1] ||
       pin_resp_in[1] != PIN_RESP_INHIBIT);
  endproperty
  a_inhibit: assert property (p_inhibit) // R16
    else $error("external pin low did not request three-state");
endmodule : fspp_top
`default_nettype wire

// ---- fspp_share_partner.sv ----
// Purpose: Other channel or controller sharing the two fault lines
// Assumes: Each line has a pull-up; any party may pull it low
// Notes:   Wire level merges this party's pull with the block's enable
`timescale 1ns/1ps
`default_nettype none
module fspp_share_partner (
  input  wire logic [1:0] pull_req_in,
  input  wire logic [1:0] dut_oe_n_in,
  output logic      [1:0] wire_level_out
);
  // A line nobody pulls rises to the pull-up level, never a stale value
  assign wire_level_out = ~(pull_req_in | ~dut_oe_n_in);
endmodule : fspp_share_partner
`default_nettype wire

// ---- fault_share_pin_propagation_tb.sv ----
// Purpose: Self-checking bench for the fault-share pin block
// Assumes: Hold length shortened to 20 cycles
// Notes:   Expected values queue up; a monitor compares on each result
`timescale 1ns/1ps
`default_nettype none
module fault_share_pin_propagation_tb;
  import fspp_pkg::*;
  localparam int HOLD = 20;
  logic clk = 1'b0, rst_n = 1'b0, cv = 1'b0, cw = 1'b0, cp = 1'b0;
  logic [7:0] cc = 8'h00;
  logic [15:0] cd = 16'h0000, rdata, nvm_m0 = 16'h0000, nvm_m1 = 16'h0000;
  logic hit, nvm_rst = 1'b0, iot = 1'b0, vov = 1'b0;
  logic [1:0] run = 2'b11, osd = 2'b00, dec = 2'b11, cfg = 2'b11;
  logic [1:0] ton = 2'b00, pgc = 2'b00, ut = 2'b00, eot = 2'b00;
  logic [1:0] ioc = 2'b00, uv = 2'b00, ov = 2'b00, pull = 2'b00;
  logic [1:0] wire_lvl, pin_o, oe_n, sd, ts;
  logic [15:0] nvm_o0, nvm_o1;
  logic [31:0] nv_e;
  logic [31:0] nv_q[$];
  logic [1:0][1:0] resp = '0;
  logic [1:0][7:0] presp = '0;
  logic [31:0] seed = 32'd81;
  logic [15:0] rd_q[$];
  logic [5:0] pin_q[$];
  int miscompares = 0, n_compared = 0;
  int bits[9] = '{BIT_TON_MAX, BIT_PG_CMP, BIT_INT_OT, BIT_EXT_UT, BIT_EXT_OT,
                  BIT_VIN_OV, BIT_IOUT_OC, BIT_VOUT_UV, BIT_VOUT_OV};

  always #5 clk = ~clk;

  fspp_top #(.SHORT_HOLD_CYC(HOLD)) DUT (
    .sys_clk_in(clk), .reset_n_in(rst_n), .cmd_valid_in(cv),
    .cmd_write_in(cw), .cmd_code_in(cc), .cmd_page_in(cp),
    .cmd_wdata_in(cd), .cmd_rdata_out(rdata), .cmd_hit_out(hit),
    .nvm_restore_in(nvm_rst), .nvm_mask0_in(nvm_m0), .nvm_mask1_in(nvm_m1),
    .nvm_mask0_out(nvm_o0), .nvm_mask1_out(nvm_o1), .run_cmd_in(run),
    .off_seq_done_in(osd), .decayed_in(dec), .chan_cfg_bit0_in(cfg),
    .ton_max_fault_in(ton), .power_good_cmp_uv_in(pgc),
    .internal_overtemperature_fault_in(iot),
    .external_undertemperature_fault_in(ut),
    .external_overtemperature_fault_in(eot), .input_overvoltage_fault_in(vov),
    .output_overcurrent_fault_in(ioc), .output_undervoltage_fault_in(uv),
    .output_overvoltage_fault_in(ov), .resp_ton_max_in(resp),
    .resp_int_ot_in(resp), .resp_ext_ut_in(resp), .resp_ext_ot_in(resp),
    .resp_vin_ov_in(resp), .resp_iout_oc_in(resp), .resp_vout_uv_in(resp),
    .resp_vout_ov_in(resp), .pin_resp_in(presp),
    .fault_share_pin_in(wire_lvl), .fault_share_pin_out(pin_o),
    .fault_share_pin_oe_n_out(oe_n), .shutdown_req_out(sd),
    .tristate_req_out(ts));

  fspp_share_partner partner (.pull_req_in(pull), .dut_oe_n_in(oe_n),
                              .wire_level_out(wire_lvl));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_word

  task automatic cmp_pins(input logic [5:0] e, input logic [5:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_pins

  // Tasks are entered just after a rising edge and return just after one
  task automatic wr(input logic p, input logic [15:0] d,
                    input logic [7:0] c = CMD_PROPAGATE_MASK);
    cv <= 1'b1;
    cw <= 1'b1;
    cc <= c;
    cp <= p;
    cd <= d;
    @(posedge clk);
    cv <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic p, input logic [15:0] e);
    cv <= 1'b1;
    cw <= 1'b0;
    cc <= CMD_PROPAGATE_MASK;
    cp <= p;
    @(posedge clk);
    cv <= 1'b0;
    rd_q.push_back(e);
    @(posedge clk);
  endtask : rd

  // Expected order: tristate, shutdown, active-low pin enable
  task automatic expect_pins(input logic [5:0] e, input int n);
    repeat (n) @(posedge clk);
    pin_q.push_back(e);
    @(posedge clk);
  endtask : expect_pins

  task automatic set_fault(input int b, input logic [1:0] v);
    case (b)
      BIT_TON_MAX: ton <= v;
      BIT_PG_CMP:  pgc <= v;
      BIT_INT_OT:  iot <= |v;
      BIT_EXT_UT:  ut  <= v;
      BIT_EXT_OT:  eot <= v;
      BIT_VIN_OV:  vov <= |v;
      BIT_IOUT_OC: ioc <= v;
      BIT_VOUT_UV: uv  <= v;
      default:     ov  <= v;
    endcase
  endtask : set_fault

  always @(negedge clk) begin
    // A missing hit must fail, not leave the note waiting forever
    if (rd_q.size() > 0)
      cmp_word(rd_q.pop_front(), (hit === 1'b1) ? rdata : 16'hxxxx);
    if (pin_q.size() > 0) begin
      cmp_pins(pin_q.pop_front(), {ts, sd, oe_n});
      cmp_pins(6'h00, {4'h0, pin_o});
    end
    if (nv_q.size() > 0) begin
      nv_e = nv_q.pop_front();
      cmp_word(nv_e[15:0], nvm_o0);
      cmp_word(nv_e[31:16], nvm_o1);
    end
  end

  initial begin : watchdog
    #50us;
    miscompares++;
    $display("watchdog expired");
    summarize();
  end

  initial begin : main
    logic [15:0] m;
    logic [1:0]  fp, sd_e, r;
    logic [5:0]  pe;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(1'b0, MASK_RESET);
    rd(1'b1, MASK_RESET);
    m = 16'(xs()) & ~MASK_RESERVED;
    wr(1'b1, m);
    rd(1'b0, MASK_RESET);
    rd(1'b1, m);
    wr(1'b1, ~m, 8'hd3);
    rd(1'b1, m);
    $display("test registers done");
    foreach (bits[i]) begin
      m = 16'h0001 << bits[i];
      for (int pg = 1; pg < 3; pg++) begin
        wr(1'b0, m);
        wr(1'b1, m);
        fp = (bits[i] == BIT_INT_OT || bits[i] == BIT_VIN_OV) ?
             2'b11 : pg[1:0];
        r = 2'(xs() % 3) + 2'h1;
        resp <= {r, r};
        set_fault(bits[i], pg[1:0]);
        sd_e = (bits[i] != BIT_PG_CMP && r == RESP_SHUTDOWN) ? fp : 2'b00;
        pe = {2'b00, sd_e, ~fp};
        expect_pins(pe, 2);
        resp <= '0;
        expect_pins({4'h0, (bits[i] == BIT_PG_CMP) ? ~fp : 2'b11}, 2);
        resp <= {r, r};
        wr(1'b0, ~m & ~MASK_RESERVED);
        wr(1'b1, ~m & ~MASK_RESERVED);
        pe[1:0] = 2'b11;
        expect_pins(pe, 1);
        set_fault(bits[i], 2'b00);
      end
    end
    $display("test fault map done");
    wr(1'b0, 16'h0003);
    wr(1'b1, 16'h0000);
    resp <= {RESP_SHUTDOWN, RESP_SHUTDOWN};
    ov <= 2'b01;
    uv <= 2'b01;
    expect_pins(6'b00_01_10, 2);
    ov <= 2'b00;
    expect_pins(6'b00_01_10, 2);
    uv <= 2'b00;
    expect_pins(6'b00_00_11, 2);
    $display("test combine done");
    presp[1] <= PIN_RESP_INHIBIT;
    pull <= 2'b10;
    expect_pins(6'b10_00_11, 4);
    presp[1] <= PIN_RESP_IGNORE;
    expect_pins(6'b00_00_11, 2);
    pull <= 2'b00;
    $display("test pin response done");
    wr(1'b0, 16'h0001 << BIT_SHORT_CYCLE);
    run <= 2'b10;
    @(posedge clk);
    run <= 2'b11;
    expect_pins(6'b00_00_10, 3);
    osd <= 2'b01;
    expect_pins(6'b00_00_10, 10);
    // Last pulled cycle, then the very next one must be released
    expect_pins(6'b00_00_10, HOLD - 10);
    expect_pins(6'b00_00_11, 0);
    osd <= 2'b00;
    $display("test short cycle done");
    wr(1'b0, 16'h0000);
    wr(1'b1, 16'h0001 << BIT_DECAY_HOLD);
    cfg <= 2'b01;
    dec <= 2'b01;
    run <= 2'b01;
    @(posedge clk);
    run <= 2'b11;
    expect_pins(6'b00_00_01, 3);
    dec <= 2'b11;
    expect_pins(6'b00_00_11, 3);
    $display("test decay hold done");
    m = 16'(xs()) & ~MASK_RESERVED;
    nvm_m0 <= m;
    nvm_m1 <= ~m & ~MASK_RESERVED;
    nvm_rst <= 1'b1;
    // A write in the restore cycle is lost: restore wins
    wr(1'b0, ~m & ~MASK_RESERVED);
    nvm_rst <= 1'b0;
    nv_q.push_back({~m & ~MASK_RESERVED, m});
    rd(1'b0, m);
    rd(1'b1, ~m & ~MASK_RESERVED);
    $display("test restore done");
    summarize();
  end
endmodule : fault_share_pin_propagation_tb
`default_nettype wire
